// ### pkg/asp_pkg.sv
// Purpose: constants and types of the absolute scale serial position output
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes: times are kept in ns, cycle counts are derived from them
`default_nettype none
package asp_pkg;
  // clock and timing
  localparam int CLK_MHZ = 40;
  localparam int SSI_RECOV_NS = 25000;
  localparam int BISS_RECOV_NS = 5000;
  localparam int REFRESH_NS = 25000;
  localparam int TIMEOUT_NS = 1600000;
  localparam int SSI_RECOV_CYC = (SSI_RECOV_NS * CLK_MHZ) / 1000;
  localparam int BISS_RECOV_CYC = (BISS_RECOV_NS * CLK_MHZ) / 1000;
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  // frame layout
  localparam int POS_W_COARSE = 26;
  localparam int SSI_POS_W_FINE = 30;
  localparam int BISS_POS_W_FINE = 32;
  localparam logic [31:0] MASK_26 = 32'h03ff_ffff;
  localparam logic [31:0] MASK_30 = 32'h3fff_ffff;
  localparam logic [6:0] CRC_POLY = 7'h43;
  localparam logic [2:0] BISS_HDR = 3'h2;  // ack low, start high, cds low
  localparam int BISS_EXTRA = 11;          // header, error, warning, crc
  localparam int FRAME_W = 48;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_POS = 8'h08;
  localparam logic [7:0] REG_FRAMES = 8'h0c;
  localparam int CTRL_BISS = 0;
  localparam int CTRL_FINE = 1;
  localparam int CTRL_GRAY = 2;
  localparam int CTRL_PAR_EN = 3;
  localparam int CTRL_PAR_ODD = 4;
  localparam int CTRL_ERR_EN = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OK = 1;
  localparam int STAT_WARN = 2;
  localparam int STAT_TOUT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // line states
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_RECOV} asp_state_t;
endpackage
`default_nettype wire

// ### core/asp_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: single clock, synchronous active-low reset
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module asp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // asynchronous input and synchronised output
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } asp_sync_t;
  asp_sync_t s_r;
  asp_sync_t s_nxt;

  // two stage shift
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = D;
    s_nxt.sync = s_r.meta;
    if (!RST_B) begin
      s_nxt.meta = INIT;
      s_nxt.sync = INIT;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  assign Q = s_r.sync;
endmodule // asp_sync
`default_nettype wire

// ### core/asp_core.sv
// Purpose: serial position output of an absolute scale, SSI or BiSS-C slave
// Assumes: master drives the serial clock; position sampled by logic on CLK
// Notes: registers over AXI4-Lite; serial clock sampled and edge-detected on CLK
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module asp_core
  import asp_pkg::*;
#(
  parameter int TIMEOUT_CYC_P = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // position source on CLK
  input wire logic [31:0] POS_DATA,
  input wire logic POS_OK,
  input wire logic READ_OK,
  // serial link
  input wire logic SERIAL_CLOCK_PAIR,
  output logic DATA_OUT
);
  localparam logic [16:0] TO_LIM = 17'(TIMEOUT_CYC_P - 1);
  localparam logic [16:0] SR_LIM = 17'(SSI_RECOV_CYC - 1);
  localparam logic [16:0] BR_LIM = 17'(BISS_RECOV_CYC - 1);
  localparam logic [15:0] RF_LIM = 16'(REFRESH_CYC - 1);

  typedef struct packed {
    asp_state_t st;
    logic clk_q;
    logic [16:0] idle;
    logic [15:0] refr;
    logic [47:0] sr;
    logic [5:0] left;
    logic low;
    logic [31:0] pos;
    logic ok;
    logic warn;
    logic [5:0] ctrl;
    logic tout;
    logic [31:0] frames;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic dout;
  } asp_core_t;

  asp_core_t s_r;
  asp_core_t s_nxt;
  logic clk_s;
  logic rise;
  logic fall;
  logic tick;
  logic [47:0] f_sr;
  logic [5:0] f_len;
  logic f_low;

  // serial clock enters through two flip-flops
  asp_sync #(.W(1), .INIT(1'b1)) u_clk_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .D(SERIAL_CLOCK_PAIR),
    .Q(clk_s)
  );

  // six-bit crc, msb first, zero seed
  function automatic logic [5:0] crc6(input logic [33:0] d);
    logic [5:0] c;
    logic fb;
    c = '0;
    for (int i = 33; i >= 0; i--) begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY[5:0];
      end
    end
    return c;
  endfunction

  // edges of the synchronised serial clock and refresh tick
  assign rise = clk_s & ~s_r.clk_q;
  assign fall = ~clk_s & s_r.clk_q;
  assign tick = (s_r.refr == RF_LIM);

  // frame image built from the held sample and the configuration
  always_comb begin
    logic biss;
    logic fine;
    logic [31:0] pm;
    logic [33:0] d;
    logic [47:0] f;
    int w;
    biss = s_r.ctrl[CTRL_BISS];
    fine = s_r.ctrl[CTRL_FINE];
    pm = '0;
    d = '0;
    f = '0;
    w = POS_W_COARSE;
    if (biss) begin
      w = fine ? BISS_POS_W_FINE : POS_W_COARSE;
      pm = fine ? s_r.pos : (s_r.pos & MASK_26);
    end else begin
      w = fine ? SSI_POS_W_FINE : POS_W_COARSE;
      pm = s_r.pos & (fine ? MASK_30 : MASK_26);
    end
    // invalid reading with an error bit sends a zero position
    if (!s_r.ok && (biss || (s_r.ctrl[CTRL_ERR_EN] && !s_r.ctrl[CTRL_GRAY]))) begin
      pm = '0;
    end
    f_low = 1'b0;
    if (biss) begin
      d = {2'h0, pm} << 2;
      d[1] = s_r.ok;
      d[0] = s_r.warn;
      // header, position, error, warning, inverted crc
      f = ({45'h0, BISS_HDR} << (w + 8)) | ({14'h0, d} << 6) | {42'h0, ~crc6(d)};
      f_len = 6'(w + BISS_EXTRA);
    end else if (s_r.ctrl[CTRL_GRAY]) begin
      f = {16'h0, pm ^ (pm >> 1)};
      f_len = 6'(w);
      f_low = !s_r.ok;
    end else begin
      f = {16'h0, pm};
      f_len = 6'(w);
      if (s_r.ctrl[CTRL_PAR_EN]) begin
        f = {f[46:0], s_r.ctrl[CTRL_PAR_ODD] ? ~^pm : ^pm};
        f_len = f_len + 6'h1;
      end
      if (s_r.ctrl[CTRL_ERR_EN]) begin
        f = {f[46:0], s_r.ok};
        f_len = f_len + 6'h1;
      end else begin
        f_low = !s_r.ok;
      end
    end
    f_sr = f << (FRAME_W - int'(f_len));
  end

  // next state: bus slave, line sequencer, sampling
  always_comb begin
    logic [16:0] rlim;
    rlim = s_r.ctrl[CTRL_BISS] ? BR_LIM : SR_LIM;
    s_nxt = s_r;
    s_nxt.clk_q = clk_s;
    // write address and data taken in either order
    if (S_AXI_AWVALID && !s_r.aw_have) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_r.w_have) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstrb = S_AXI_WSTRB;
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (s_r.awaddr)
        REG_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.ctrl = s_r.wdata[5:0];
          end
        end
        REG_STAT: begin
          if (s_r.wstrb[0] && s_r.wdata[STAT_TOUT]) begin
            s_nxt.tout = 1'b0;
          end
        end
        REG_POS, REG_FRAMES: ;
        default: s_nxt.bresp = RESP_DECERR;
      endcase
    end
    // read answer one cycle after the address
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      case (S_AXI_ARADDR)
        REG_CTRL: s_nxt.rdata = {26'h0, s_r.ctrl};
        REG_STAT: s_nxt.rdata = {28'h0, s_r.tout, s_r.warn, s_r.ok, s_r.st != ST_IDLE};
        REG_POS: s_nxt.rdata = s_r.pos;
        REG_FRAMES: s_nxt.rdata = s_r.frames;
        default: s_nxt.rresp = RESP_DECERR;
      endcase
    end
    // clock inactivity counter, saturating
    if (rise || fall) begin
      s_nxt.idle = '0;
    end else if (s_r.idle != 17'h1ffff) begin
      s_nxt.idle = s_r.idle + 17'h1;
    end
    s_nxt.refr = tick ? 16'h0 : s_r.refr + 16'h1;
    // line sequencer
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.dout = 1'b1;
        if (fall) begin
          s_nxt.sr = f_sr;
          s_nxt.left = f_len;
          s_nxt.low = f_low;
          s_nxt.st = ST_SHIFT;
        end else if (tick) begin
          s_nxt.pos = POS_DATA;
          s_nxt.ok = POS_OK;
          s_nxt.warn = READ_OK;
        end
      end
      ST_SHIFT: begin
        if (rise) begin
          s_nxt.dout = s_r.low ? 1'b0 : s_r.sr[47];
          s_nxt.sr = {s_r.sr[46:0], 1'b0};
          s_nxt.left = s_r.left - 6'h1;
          if (s_r.left == 6'h1) begin
            s_nxt.st = ST_RECOV;
          end
        end else if (!fall && s_r.idle == TO_LIM) begin
          // abandoned transfer: back to ready with a fresh sample
          s_nxt.st = ST_IDLE;
          s_nxt.dout = 1'b1;
          s_nxt.tout = 1'b1;
          s_nxt.pos = POS_DATA;
          s_nxt.ok = POS_OK;
          s_nxt.warn = READ_OK;
        end
      end
      ST_RECOV: begin
        if (rise) begin
          s_nxt.dout = 1'b0;
        end else if (!fall && s_r.idle >= rlim) begin
          s_nxt.st = ST_IDLE;
          s_nxt.dout = 1'b1;
          s_nxt.frames = s_r.frames + 32'h1;
          s_nxt.pos = POS_DATA;
          s_nxt.ok = POS_OK;
          s_nxt.warn = READ_OK;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (!RST_B) begin
      s_nxt = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.clk_q = 1'b1;
      s_nxt.dout = 1'b1;
      s_nxt.ctrl = CTRL_RST;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  // port drive
  assign S_AXI_AWREADY = !s_r.aw_have;
  assign S_AXI_WREADY = !s_r.w_have;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = !s_r.rvalid;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;
  assign DATA_OUT = s_r.dout;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_load;
    s_r.st == ST_IDLE && fall;
  endsequence
  sequence s_quiet_end(logic [16:0] lim);
    !rise && !fall && s_r.idle >= lim;
  endsequence

  chk_idle_line_high: assert property (
    s_r.st == ST_IDLE |-> DATA_OUT)
    else $error("line not high while ready");
  chk_msb_shift: assert property (
    s_r.st == ST_SHIFT && rise && !s_r.low |=> DATA_OUT == $past(s_r.sr[47]))
    else $error("wrong bit shifted out");
  chk_force_low: assert property (
    s_r.st == ST_SHIFT && s_r.low && rise |=> !DATA_OUT [*1] ##1 (s_r.low || s_r.st != ST_SHIFT))
    else $error("invalid position not held low");
  chk_frame_len: assert property (
    s_load |=> s_r.left == (s_r.ctrl[CTRL_BISS] ? (s_r.ctrl[CTRL_FINE] ? 6'd43 : 6'd37)
      : (s_r.ctrl[CTRL_FINE] ? 6'd30 : 6'd26) + (s_r.ctrl[CTRL_GRAY] ? 6'd0
      : 6'(s_r.ctrl[CTRL_PAR_EN]) + 6'(s_r.ctrl[CTRL_ERR_EN]))))
    else $error("frame length wrong");
  chk_timeout_abort: assert property (
    s_r.st == ST_SHIFT && !rise && !fall && s_r.idle == TO_LIM
      |=> s_r.st == ST_IDLE && DATA_OUT && s_r.tout)
    else $error("stalled transfer not abandoned");
  chk_ssi_recovery: assert property (
    (s_r.st == ST_RECOV && !s_r.ctrl[CTRL_BISS]) and s_quiet_end(SR_LIM)
      |=> s_r.st == ST_IDLE && s_r.pos == $past(POS_DATA))
    else $error("no fresh position after ssi recovery");
  chk_biss_recovery: assert property (
    (s_r.st == ST_RECOV && s_r.ctrl[CTRL_BISS]) and s_quiet_end(BR_LIM)
      |=> s_r.st == ST_IDLE && s_r.pos == $past(POS_DATA))
    else $error("no fresh position after biss recovery");
  chk_refresh_pos: assert property (
    s_r.st == ST_IDLE && !fall && tick |=> s_r.pos == $past(POS_DATA) && s_r.refr == 16'h0)
    else $error("held position not refreshed");
  chk_biss_header: assert property (
    s_load and s_r.ctrl[CTRL_BISS] |=> s_r.sr[47:45] == BISS_HDR)
    else $error("biss header wrong");
endmodule // asp_core
`default_nettype wire

// ### sim/asp_mst.sv
// Purpose: serial master model that clocks position frames out of the scale
// Assumes: clock idles high, frame is loaded on the first falling edge
// Notes: each bit is taken at the end of the low half, just before the rise after the one that launched it
`timescale 1ns/1ps
`default_nettype none
module asp_mst (
  // serial lines
  output var logic sck,
  input wire logic sdi
);
  // clock stands high outside frames
  initial sck = 1'b1;
  // n bits at half period h ns, then one more rise back to idle
  task automatic frame(input int n, input int h, output logic [63:0] b);
    b = '0;
    #7;
    for (int i = 0; i <= n; i++) begin
      sck = 1'b0;
      #(h);
      if (i > 0) b = {b[62:0], sdi};
      sck = 1'b1;
      #(h);
    end
  endtask
  // broken frame: a few clocks, then the clock stays quiet
  task automatic part(input int n, input int h);
    #7;
    repeat (n) begin
      sck = 1'b0;
      #(h);
      sck = 1'b1;
      #(h);
    end
  endtask
endmodule // asp_mst
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench of the serial position output
// Assumes: 40 MHz clock, master model on the serial pins
// Notes: frames are predicted from the option bits and the held sample
`timescale 1ns/1ps
`default_nettype none
module tb import asp_pkg::*; ;
  localparam int TOUT = 2000;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] aa = '0;
  logic [7:0] ra = '0;
  logic [31:0] wd = '0;
  logic [31:0] pd = '0;
  logic [31:0] v;
  logic [31:0] rdata;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pok = 0, rok = 1;
  logic awr, wrr, bv, arr, rv, sck, dout;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int err_total = 0, n_compared = 0, seed = 66083, nf = 0;
  // design and serial master
  asp_core #(.TIMEOUT_CYC_P(TOUT)) dut_u (.CLK(CLK), .RST_B(RST_B),
    .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .POS_DATA(pd), .POS_OK(pok), .READ_OK(rok),
    .SERIAL_CLOCK_PAIR(sck), .DATA_OUT(dout));
  asp_mst m_u (.sck(sck), .sdi(dout));
  // 25 ns system clock
  initial forever #12.5 CLK = ~CLK;
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  // register write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    logic [1:0] r;
    @(posedge CLK);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge CLK);
      ta = pa && awr;
      tw = pw && wrr;
      @(posedge CLK);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge CLK); while (bv !== 1'b1);
    r = bresp;
    @(posedge CLK);
    br <= 1'b0;
    chk(64'(r), 64'(er), "bresp");
  endtask
  // register read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge CLK);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge CLK); while (arr !== 1'b1);
    @(posedge CLK);
    arv <= 1'b0;
    do @(negedge CLK); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge CLK);
    rr <= 1'b0;
    chk(64'(r), 64'(er), "rresp");
  endtask
  // reference frame: c bits 0 biss, 1 fine, 2 gray, 3 parity, 4 odd, 5 error
  function automatic logic [63:0] mk(input logic [5:0] c, input logic ok, input logic rdk,
    input logic [31:0] p, output int n);
    int w;
    logic [31:0] q;
    logic [63:0] f;
    logic [5:0] s;
    logic fb;
    w = c[0] ? (c[1] ? 32 : 26) : (c[1] ? 30 : 26);
    q = ok ? p & ~(32'hffffffff << w) : '0;
    if (c[2] && !c[0]) q = q ^ (q >> 1);
    f = c[0] ? 64'h2 : 64'h0;
    n = c[0] ? 3 + w : w;
    f = (f << w) | 64'(q);
    if (c[0]) begin
      f = {f[61:0], ok, rdk};
      s = '0;
      for (int i = w + 1; i >= 0; i--) begin
        fb = s[5] ^ ((i > 1) ? q[i-2] : (i > 0 ? ok : rdk));
        s = {s[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
      end
      f = {f[57:0], ~s};
      n += 8;
    end else begin
      if (c[3] && !c[2]) begin
        f = {f[62:0], ^q ^ c[4]};
        n++;
      end
      if (c[5] && !c[2]) begin
        f = {f[62:0], ok};
        n++;
      end
      if (!ok && (c[2] || !c[5])) f = '0;
    end
    return f;
  endfunction
  // one frame; bk reads straight after the previous recovery
  task automatic tst(input logic [5:0] c, input logic ok, input logic rdk, input logic bk);
    logic [63:0] e, g;
    int n, h, k;
    h = c[0] ? 100 : 500;
    if (!bk) begin
      @(posedge CLK);
      pd <= $random(seed);
      pok <= ok;
      rok <= rdk;
      wr(REG_CTRL, 32'(c), RESP_OKAY);
      repeat (1100) @(posedge CLK);
    end
    e = mk(c, ok, rdk, pd, n) << 1;
    m_u.frame(n + 1, h, g);
    chk(g, e, "frame");
    @(posedge CLK);
    pd <= $random(seed);
    k = 0;
    // line is looked at between clock edges, away from its launching edge
    do begin
      @(negedge CLK);
      k++;
    end while (dout !== 1'b1 && k < (c[0] ? 215 : 1015));
    chk(64'(dout), 64'h1, "recovery");
    chk(64'(k >= (c[0] ? BISS_RECOV_CYC : SSI_RECOV_CYC) - 30), 64'h1, "recovery early");
    nf++;
    $display("frame test %0h done", c);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    rd(REG_CTRL, v, RESP_OKAY);
    chk(64'(v), 64'(CTRL_RST), "ctrl reset");
    rd(8'h10, v, RESP_DECERR);
    chk(64'(v), 64'h0, "unmapped read");
    wr(8'h10, 32'h1, RESP_DECERR);
    $display("register test done");
    tst(6'h00, 1'b1, 1'b1, 1'b0);
    tst(6'h00, 1'b1, 1'b1, 1'b1);
    tst(6'h28, 1'b1, 1'b1, 1'b0);
    tst(6'h3a, 1'b1, 1'b1, 1'b0);
    tst(6'h2c, 1'b1, 1'b1, 1'b0);
    tst(6'h20, 1'b0, 1'b1, 1'b0);
    tst(6'h08, 1'b0, 1'b1, 1'b0);
    tst(6'h24, 1'b0, 1'b1, 1'b0);
    tst(6'h01, 1'b1, 1'b1, 1'b0);
    tst(6'h01, 1'b1, 1'b1, 1'b1);
    tst(6'h03, 1'b1, 1'b0, 1'b0);
    tst(6'h01, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, 32'(i), RESP_OKAY);
      repeat (1100) @(posedge CLK);
      m_u.part(5, i ? 100 : 500);
      repeat (TOUT + 20) @(posedge CLK);
      chk(64'(dout), 64'h1, "abort line");
      rd(REG_STAT, v, RESP_OKAY);
      chk(64'(v[STAT_TOUT]), 64'h1, "abort flag");
      wr(REG_STAT, 32'h8, RESP_OKAY);
      $display("abort test %0d done", i);
    end
    rd(REG_FRAMES, v, RESP_OKAY);
    chk(64'(v), 64'(nf), "frame count");
    // an abandoned transfer takes a fresh sample on its way back to ready
    rd(REG_POS, v, RESP_OKAY);
    chk(64'(v), 64'(pd), "held position");
    stop_test;
  end
  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge CLK);
    err_total++;
    stop_test;
  end
endmodule // tb
`default_nettype wire
